// ---- ccbo_datapath.sv ----
/*
  clear, complement and decimal-adjust datapath of the core.
  holds accumulator, zero-result and watchdog status flags; writes data memory
  through a one-cycle write strobe. assumes decode presents one op per cycle
  with the memory byte already read onto MEM_RDATA_I, same clock domain.
  decimal adjust tests the high nibble after the low carry has rippled in,
  so a ripple out of nibble f still adds six and sets the carry.
*/
// How it works
// - byte clear writes zero to memory
// - bit clear zeroes one selected bit
// - watchdog clear restarts counter, clears both flags
// - complement in place writes inverse, sets zero
// - complement to accumulator loads inverse, sets zero
// - complement to accumulator leaves memory alone
// - decimal adjust writes corrected accumulator to memory
// - low nibble plus six if above nine/half-carry
// - high nibble plus six if above nine/carry
module ccbo_datapath (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic OP_VALID_I,
  input wire logic [2:0] OP_CODE_I,
  input wire logic [6:0] OP_ADDR_I,
  input wire logic [2:0] OP_BIT_I,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic [7:0] ACC_I,
  input wire logic ACC_LOAD_I,
  input wire logic CARRY_FLAG_I,
  input wire logic HALF_CARRY_FLAG_I,
  input wire logic TIMEOUT_SET_I,
  input wire logic POWER_DOWN_SET_I,
  output logic MEM_WE_O,
  output logic [6:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic [7:0] ACC_O,
  output logic ZERO_FLAG_O,
  output logic CARRY_FLAG_O,
  output logic WATCHDOG_COUNTER_CLEAR_O,
  output logic TIMEOUT_STATUS_FLAG_O,
  output logic POWER_DOWN_STATUS_FLAG_O
);
`include "ccbo_defines.svh"

  // registered state and next values
  logic mem_we_r, mem_we_nxt;
  ccbo_pkg::ccbo_addr_t mem_addr_r, mem_addr_nxt;
  ccbo_pkg::ccbo_byte_t mem_wdata_r, mem_wdata_nxt;
  ccbo_pkg::ccbo_byte_t acc_r, acc_nxt;
  logic zero_r, zero_nxt;
  logic carry_r, carry_nxt;
  logic wdt_clr_r, wdt_clr_nxt;
  logic timeout_r, timeout_nxt;
  logic pdown_r, pdown_nxt;
  // nibble corrector links and helpers
  logic [3:0] lo_adj, hi_adj;
  logic [4:0] hi_sum;
  logic lo_carry, hi_carry, hi_force;
  ccbo_pkg::ccbo_byte_t inv_byte;
  ccbo_pkg::ccbo_byte_t bit_mask;

  // low nibble corrector
  ccbo_nibble_adj u_lo (
    .nib_i(acc_r[3:0]),
    .force_i(HALF_CARRY_FLAG_I),
    .nib_o(lo_adj),
    .carry_o(lo_carry)
  );

  // high nibble plus low carry, five bits so a ripple out of f is kept
  assign hi_sum = {1'b0, acc_r[7:4]} + {4'h0, lo_carry};
  // a ripple past the nibble counts as above nine
  assign hi_force = CARRY_FLAG_I | hi_sum[4];
  ccbo_nibble_adj u_hi (
    .nib_i(hi_sum[3:0]),
    .force_i(hi_force),
    .nib_o(hi_adj),
    .carry_o(hi_carry)
  );

  // complement and bit-clear helpers
  assign inv_byte = ~MEM_RDATA_I;
  assign bit_mask = ~(8'h01 << OP_BIT_I);

  // next state of datapath registers
  always_comb begin
    mem_we_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    acc_nxt = ACC_LOAD_I ? ACC_I : acc_r;
    zero_nxt = zero_r;
    carry_nxt = CARRY_FLAG_I;
    wdt_clr_nxt = 1'b0;
    timeout_nxt = timeout_r | TIMEOUT_SET_I;
    pdown_nxt = pdown_r | POWER_DOWN_SET_I;
    // only a valid op writes memory or claims a flag
    if (OP_VALID_I) begin
      case (OP_CODE_I)
        `CCBO_OP_BYTE_CLEAR: begin
          mem_we_nxt = 1'b1;
          mem_addr_nxt = OP_ADDR_I;
          mem_wdata_nxt = `CCBO_BYTE_ZERO;
        end
        `CCBO_OP_BIT_CLEAR: begin
          mem_we_nxt = 1'b1;
          mem_addr_nxt = OP_ADDR_I;
          mem_wdata_nxt = MEM_RDATA_I & bit_mask;
        end
        `CCBO_OP_WATCHDOG_CLEAR: begin
          wdt_clr_nxt = 1'b1;
          timeout_nxt = 1'b0;
          pdown_nxt = 1'b0;
        end
        `CCBO_OP_COMPLEMENT_IN_PLACE: begin
          mem_we_nxt = 1'b1;
          mem_addr_nxt = OP_ADDR_I;
          mem_wdata_nxt = inv_byte;
          zero_nxt = (inv_byte == `CCBO_BYTE_ZERO);
        end
        `CCBO_OP_COMPLEMENT_TO_ACC: begin
          acc_nxt = inv_byte;
          zero_nxt = (inv_byte == `CCBO_BYTE_ZERO);
        end
        `CCBO_OP_DECIMAL_ADJUST: begin
          mem_we_nxt = 1'b1;
          mem_addr_nxt = OP_ADDR_I;
          mem_wdata_nxt = {hi_adj, lo_adj};
          carry_nxt = CARRY_FLAG_I | hi_carry | hi_sum[4];
        end
        default: begin
          mem_we_nxt = 1'b0;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mem_we_r <= 1'b0;
      mem_addr_r <= `CCBO_ADDR_RST;
      mem_wdata_r <= `CCBO_BYTE_ZERO;
      acc_r <= `CCBO_ACC_RST;
      zero_r <= 1'b0;
      carry_r <= 1'b0;
      wdt_clr_r <= 1'b0;
      timeout_r <= 1'b0;
      pdown_r <= 1'b0;
    end else begin
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      carry_r <= carry_nxt;
      wdt_clr_r <= wdt_clr_nxt;
      timeout_r <= timeout_nxt;
      pdown_r <= pdown_nxt;
    end
  end

  // outputs straight from flip-flops
  assign MEM_WE_O = mem_we_r;
  assign MEM_ADDR_O = mem_addr_r;
  assign MEM_WDATA_O = mem_wdata_r;
  assign ACC_O = acc_r;
  assign ZERO_FLAG_O = zero_r;
  assign CARRY_FLAG_O = carry_r;
  assign WATCHDOG_COUNTER_CLEAR_O = wdt_clr_r;
  assign TIMEOUT_STATUS_FLAG_O = timeout_r;
  assign POWER_DOWN_STATUS_FLAG_O = pdown_r;

  // assertions run on the core clock, quiet in reset
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  // rule checks, one cycle after the op is taken
  chk_byte_clear_zero: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_BYTE_CLEAR) |=>
    (MEM_WE_O && MEM_WDATA_O == 8'h00 && MEM_ADDR_O == $past(OP_ADDR_I))) else $error("byte clear not zero");
  chk_bit_clear_one: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_BIT_CLEAR) |=>
    (MEM_WE_O && MEM_WDATA_O == ($past(MEM_RDATA_I) & ~(8'h01 << $past(OP_BIT_I))))) else $error("bit clear wrong");
  chk_wdt_clear_flags: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_WATCHDOG_CLEAR) |=>
    (WATCHDOG_COUNTER_CLEAR_O && !TIMEOUT_STATUS_FLAG_O && !POWER_DOWN_STATUS_FLAG_O)) else $error("wdt clear wrong");
  chk_cpl_in_place: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_IN_PLACE) |=>
    (MEM_WE_O && MEM_WDATA_O == ~$past(MEM_RDATA_I) && ZERO_FLAG_O == ($past(MEM_RDATA_I) == 8'hff)))
    else $error("complement in place wrong");
  chk_cpl_acc_load: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_TO_ACC) |=>
    (ACC_O == ~$past(MEM_RDATA_I) && ZERO_FLAG_O == ($past(MEM_RDATA_I) == 8'hff))) else $error("cpla wrong");
  chk_cpl_acc_nowrite: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_TO_ACC) |=>
    !MEM_WE_O) else $error("cpla wrote memory");
  chk_daa_writes: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST) |=> MEM_WE_O)
    else $error("daa no write");
  chk_daa_low_nib: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST) |=>
    (MEM_WDATA_O[3:0] == (($past(acc_r[3:0]) > 4'h9 || $past(HALF_CARRY_FLAG_I)) ?
    $past(acc_r[3:0]) + 4'h6 : $past(acc_r[3:0])))) else $error("daa low nibble wrong");
  chk_daa_high_keep: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST && acc_r < 8'h9a
    && !CARRY_FLAG_I && !HALF_CARRY_FLAG_I && acc_r[3:0] < 4'ha) |=> MEM_WDATA_O == $past(acc_r))
    else $error("daa high nibble wrong");
  chk_clear_zero_kept: assert property ((OP_VALID_I && (OP_CODE_I == `CCBO_OP_BYTE_CLEAR ||
    OP_CODE_I == `CCBO_OP_BIT_CLEAR)) |=> $stable(ZERO_FLAG_O)) else $error("clear changed zero flag");
  chk_clear_carry_kept: assert property ((OP_VALID_I && (OP_CODE_I == `CCBO_OP_BYTE_CLEAR ||
    OP_CODE_I == `CCBO_OP_BIT_CLEAR)) |=> CARRY_FLAG_O == $past(CARRY_FLAG_I)) else $error("clear changed carry flag");
  chk_wdt_pulse_once: assert property ((WATCHDOG_COUNTER_CLEAR_O &&
    !(OP_VALID_I && OP_CODE_I == `CCBO_OP_WATCHDOG_CLEAR)) |=> !WATCHDOG_COUNTER_CLEAR_O) else $error("wdt clear held");
  chk_cpl_place_acc: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_IN_PLACE
    && !ACC_LOAD_I) |=> $stable(ACC_O)) else $error("complement in place changed accumulator");
  chk_cpl_acc_memkept: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_TO_ACC) |=>
    ($stable(MEM_WDATA_O) && $stable(MEM_ADDR_O))) else $error("cpla changed write data");
  chk_daa_carry_out: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST
    && CARRY_FLAG_I) |=> CARRY_FLAG_O) else $error("daa carry lost");
  chk_daa_high_add: assert property ((OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST
    && acc_r[7:4] > 4'h9 && acc_r[3:0] < 4'ha && !HALF_CARRY_FLAG_I) |=> (CARRY_FLAG_O &&
    MEM_WDATA_O[7:4] == $past(acc_r[7:4]) + 4'h6)) else $error("daa high nibble not adjusted");

  // main scenarios
  cov_byte_clear: cover property (OP_VALID_I && OP_CODE_I == `CCBO_OP_BYTE_CLEAR);
  cov_wdt_clear: cover property (OP_VALID_I && OP_CODE_I == `CCBO_OP_WATCHDOG_CLEAR);
  cov_cpl_zero: cover property (OP_VALID_I && OP_CODE_I == `CCBO_OP_COMPLEMENT_TO_ACC && MEM_RDATA_I == 8'hff);
  cov_daa_both: cover property (OP_VALID_I && OP_CODE_I == `CCBO_OP_DECIMAL_ADJUST && acc_r == 8'h9a);
  cov_bit_clear: cover property (OP_VALID_I && OP_CODE_I == `CCBO_OP_BIT_CLEAR && OP_BIT_I == 3'h7);
endmodule : ccbo_datapath

// ---- ccbo_defines.svh ----
/*
  constants of the clear, complement and decimal-adjust datapath:
  opcode encodings, bcd thresholds, reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef CCBO_DEFINES_SVH
`define CCBO_DEFINES_SVH

`define CCBO_OP_NONE 3'h0
`define CCBO_OP_BYTE_CLEAR 3'h1
`define CCBO_OP_BIT_CLEAR 3'h2
`define CCBO_OP_WATCHDOG_CLEAR 3'h3
`define CCBO_OP_COMPLEMENT_IN_PLACE 3'h4
`define CCBO_OP_COMPLEMENT_TO_ACC 3'h5
`define CCBO_OP_DECIMAL_ADJUST 3'h6
`define CCBO_BYTE_ZERO 8'h00
`define CCBO_NIBBLE_MAX 4'h9
`define CCBO_NIBBLE_ADJ 4'h6
`define CCBO_ACC_RST 8'h00
`define CCBO_ADDR_RST 7'h00

`endif

// ---- ccbo_pkg.sv ----
/*
  types of the clear, complement and decimal-adjust datapath.
  assumes ccbo_defines.svh holds the numeric values.
*/
package ccbo_pkg;
  typedef logic [2:0] ccbo_op_t;
  typedef logic [7:0] ccbo_byte_t;
  typedef logic [6:0] ccbo_addr_t;
endpackage : ccbo_pkg

// ---- ccbo_nibble_adj.sv ----
/*
  one bcd nibble corrector: adds six when above nine or forced.
  assumes a 4-bit binary nibble from an addition of two bcd digits.
*/
module ccbo_nibble_adj (
  input wire logic [3:0] nib_i,
  input wire logic force_i,
  output logic [3:0] nib_o,
  output logic carry_o
);
`include "ccbo_defines.svh"

  logic [4:0] sum;

  // conditional add of six, carry out for the next nibble
  always_comb begin
    if ((nib_i > `CCBO_NIBBLE_MAX) || force_i) begin
      sum = {1'b0, nib_i} + {1'b0, `CCBO_NIBBLE_ADJ};
    end else begin
      sum = {1'b0, nib_i};
    end
    nib_o = sum[3:0];
    carry_o = sum[4];
  end
endmodule : ccbo_nibble_adj

// ---- ccbo_datapath_test.sv ----
/*
  self-checking bench of the clear, complement and decimal-adjust datapath.
  assumes ccbo_defines.svh and ccbo_pkg are compiled before it, one 125 MHz clock.
*/
`include "ccbo_defines.svh"
module ccbo_datapath_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, valid, acc_load, cin, hcin, to_set, pd_set;
  logic we, wdog_clr, zero, cout, to_flag, pd_flag;
  logic [2:0] code, bit_idx;
  logic [6:0] addr, waddr;
  ccbo_pkg::ccbo_byte_t rdata, acc_in, wdata, acc;
  int failures, checks;

  ccbo_datapath DUT (.SYS_CLK_I(clk), .RESETN_I(resetn), .OP_VALID_I(valid), .OP_CODE_I(code),
    .OP_ADDR_I(addr), .OP_BIT_I(bit_idx), .MEM_RDATA_I(rdata), .ACC_I(acc_in), .ACC_LOAD_I(acc_load),
    .CARRY_FLAG_I(cin), .HALF_CARRY_FLAG_I(hcin), .TIMEOUT_SET_I(to_set), .POWER_DOWN_SET_I(pd_set),
    .MEM_WE_O(we), .MEM_ADDR_O(waddr), .MEM_WDATA_O(wdata), .ACC_O(acc), .ZERO_FLAG_O(zero),
    .CARRY_FLAG_O(cout), .WATCHDOG_COUNTER_CLEAR_O(wdog_clr), .TIMEOUT_STATUS_FLAG_O(to_flag),
    .POWER_DOWN_STATUS_FLAG_O(pd_flag));

  // 8 ns clock
  always #4 clk = ~clk;

  // compare and count, four-state exact
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    checks++;
    if (seen !== expected) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  // present one op for one rising edge, result visible at the next falling edge
  task automatic run_op(input logic [2:0] c, input logic [6:0] a, input logic [2:0] b, input logic [7:0] d);
    @(negedge clk);
    valid = 1'b1; code = c; addr = a; bit_idx = b; rdata = d;
    @(negedge clk);
    valid = 1'b0; code = `CCBO_OP_NONE;
  endtask : run_op

  // both complements, memory untouched by the accumulator form
  task automatic test_complement();
    run_op(`CCBO_OP_COMPLEMENT_TO_ACC, 7'h11, 3'h0, 8'hff);
    check(acc, 8'h00);
    check(zero, 1'b1);
    check(we, 1'b0);
    run_op(`CCBO_OP_COMPLEMENT_IN_PLACE, 7'h05, 3'h0, 8'h0f);
    check({we, waddr}, {1'b1, 7'h05});
    check(wdata, 8'hf0);
    check(zero, 1'b0);
    run_op(`CCBO_OP_COMPLEMENT_IN_PLACE, 7'h06, 3'h0, 8'hff);
    check(wdata, 8'h00);
    check(zero, 1'b1);
    @(negedge clk);
    check(we, 1'b0);
  endtask : test_complement

  // byte clear with zero flag low, every bit position with it high
  task automatic test_clears();
    run_op(`CCBO_OP_COMPLEMENT_TO_ACC, 7'h11, 3'h0, 8'h00);
    check(zero, 1'b0);
    run_op(`CCBO_OP_BYTE_CLEAR, 7'h7f, 3'h0, 8'ha5);
    check({we, waddr}, {1'b1, 7'h7f});
    check(wdata, 8'h00);
    check(zero, 1'b0);
    run_op(`CCBO_OP_COMPLEMENT_TO_ACC, 7'h11, 3'h0, 8'hff);
    check(zero, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run_op(`CCBO_OP_BIT_CLEAR, 7'h22, i[2:0], 8'hff);
      check(wdata, 8'hff & ~(8'h01 << i));
      check(zero, 1'b1);
    end
    run_op(3'h7, 7'h22, 3'h0, 8'h55);
    check(we, 1'b0);
  endtask : test_clears

  // set both sticky flags, watchdog clear drops them while the sets still stand
  task automatic test_watchdog();
    @(negedge clk);
    to_set = 1'b1; pd_set = 1'b1;
    @(negedge clk);
    check({to_flag, pd_flag}, 2'b11);
    run_op(`CCBO_OP_WATCHDOG_CLEAR, 7'h00, 3'h0, 8'h00);
    to_set = 1'b0; pd_set = 1'b0;
    check({wdog_clr, to_flag, pd_flag}, 3'b100);
    @(negedge clk);
    check(wdog_clr, 1'b0);
  endtask : test_watchdog

  // reference adjust: {carry, byte}, low carry ripples upward
  function automatic logic [8:0] daa_ref(input logic [7:0] a, input logic ac, input logic c);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]};
    if (lo > 5'd9 || ac) lo = lo + 5'd6;
    hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
    if (hi > 5'd9 || c) hi = hi + 5'd6;
    return {hi[4] | c, hi[3:0], lo[3:0]};
  endfunction : daa_ref

  // load the accumulator, adjust, compare against the reference
  task automatic test_bcd();
    logic [9:0] tab [7] = '{{8'h12, 2'b00}, {8'h1b, 2'b00}, {8'ha3, 2'b00}, {8'h34, 2'b01}, {8'h05, 2'b10},
      {8'h9a, 2'b00}, {8'hfa, 2'b00}};
    logic [8:0] exp;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      acc_in = tab[i][9:2]; acc_load = 1'b1;
      @(negedge clk);
      acc_load = 1'b0;
      check(acc, tab[i][9:2]);
      hcin = tab[i][1]; cin = tab[i][0];
      exp = daa_ref(tab[i][9:2], tab[i][1], tab[i][0]);
      run_op(`CCBO_OP_DECIMAL_ADJUST, 7'h30 + i[6:0], 3'h0, 8'h00);
      check({we, waddr}, {1'b1, 7'h30 + i[6:0]});
      check(wdata, exp[7:0]);
      check(cout, exp[8]);
      hcin = 1'b0; cin = 1'b0;
    end
  endtask : test_bcd

  // counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    clk = 1'b0; resetn = 1'b0; valid = 1'b0; acc_load = 1'b0; cin = 1'b0; hcin = 1'b0;
    to_set = 1'b0; pd_set = 1'b0; code = 3'h0; bit_idx = 3'h0; addr = 7'h00;
    rdata = 8'h00; acc_in = 8'h00; failures = 0; checks = 0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    test_complement();
    test_clears();
    test_watchdog();
    test_bcd();
    wrap_up();
  end

  // hang guard, far beyond the ~66 cycles the tests need
  initial begin
    #20000;
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule : ccbo_datapath_test
